/* File: motor_stop_pkg.sv */
/*
  Constants, register map and types for the motor stop sequencer.
  Assumes a 20 MHz control clock; all intervals count in 10 ms ticks.
*/
package motor_stop_pkg;
  localparam int          CLK_HZ      = 20_000_000;
  localparam int          TICK_MS     = 10;
  localparam int          TICK_CYC    = CLK_HZ / 1000 * TICK_MS;
  localparam int          ADDR_W      = 8;
  localparam int          DATA_W      = 32;
  localparam int          TIME_W      = 20;
  localparam int          FREQ_W      = 10;
  localparam int          ANA_W       = 12;
  // Register byte addresses
  localparam logic [7:0]  OFS_CTRL    = 8'h00;
  localparam logic [7:0]  OFS_MFI     = 8'h04;
  localparam logic [7:0]  OFS_ANA_FN  = 8'h08;
  localparam logic [7:0]  OFS_BRK_PCT = 8'h0c;
  localparam logic [7:0]  OFS_NOLOAD  = 8'h10;
  localparam logic [7:0]  OFS_START_T = 8'h14;
  localparam logic [7:0]  OFS_STOP_T  = 8'h18;
  localparam logic [7:0]  OFS_MIN_OFF = 8'h1c;
  localparam logic [7:0]  OFS_DECEL_T = 8'h20;
  localparam logic [7:0]  OFS_FAST_T  = 8'h24;
  localparam logic [7:0]  OFS_STATUS  = 8'h28;
  // Control register fields
  localparam int          CTRL_METH_LSB = 0;
  localparam int          CTRL_UNIT_BIT = 2;
  localparam int          CTRL_FLUX_BIT = 3;
  // Reset values
  localparam logic [1:0]  RST_METHOD  = 2'h0;
  localparam logic        RST_UNIT    = 1'b1;
  localparam logic [6:0]  RST_BRK_PCT = 7'h32;
  localparam logic [6:0]  RST_NOLOAD  = 7'h1e;
  localparam logic [15:0] RST_START_T = 16'h0000;
  localparam logic [15:0] RST_STOP_T  = 16'h0032;
  localparam logic [15:0] RST_MIN_OFF = 16'h0032;
  localparam logic [15:0] RST_RAMP_T  = 16'h0064;
  // Limits
  localparam logic [6:0]  PCT_MAX     = 7'h64;
  localparam logic [15:0] BRK_T_MAX   = 16'h03e8;
  localparam logic [15:0] RAMP_T_MAX  = 16'hea60;
  localparam logic [19:0] UNIT_TENTH  = 20'h0000a;
  // Input function codes
  localparam logic [7:0]  MFI_FAST_NO = 8'h0f;
  localparam logic [7:0]  MFI_FAST_NC = 8'h11;
  localparam logic [7:0]  MFI_DC_BRK  = 8'h3c;
  localparam logic [7:0]  ANA_FN_BRK  = 8'h06;
  localparam logic [7:0]  ANA_SCALE   = 8'h65;
  localparam logic [9:0]  FREQ_FLOOR  = 10'h066;

  typedef enum logic [1:0] {
    STOP_RAMP  = 2'b00,
    STOP_COAST = 2'b01,
    STOP_DCB   = 2'b10,
    STOP_TIMED = 2'b11
  } stop_method_t;

  typedef enum logic [3:0] {
    ST_IDLE      = 4'b0000,
    ST_START_BRK = 4'b0001,
    ST_RUN       = 4'b0010,
    ST_RAMP      = 4'b0011,
    ST_OFF_WAIT  = 4'b0100,
    ST_STOP_BRK  = 4'b0101,
    ST_COAST_LCK = 4'b0110,
    ST_EXT_BRK   = 4'b0111,
    ST_FAST      = 4'b1000,
    ST_FAST_HOLD = 4'b1001
  } state_t;
endpackage

/* File: interval_if.sv */
/*
  Load/expiry link between the sequencer and its interval counter.
  Assumes one clock shared by both ends.
*/
`timescale 1ns/1ps
interface interval_if;
  import motor_stop_pkg::*;
  logic              load;
  logic [TIME_W-1:0] ticks;
  logic              expired;
  modport ctrl (output load, output ticks, input expired);
  modport cnt  (input load, input ticks, output expired);
endinterface

/* File: interval_timer.sv */
/*
  Down-counter of 10 ms ticks with a cycle prescaler.
  Assumes load is a one-cycle pulse; expired is a level, valid the
  cycle after load.
*/
`timescale 1ns/1ps
module interval_timer
  import motor_stop_pkg::*;
#(
  parameter int TICK_CYCLES = TICK_CYC
) (
  input  wire logic clk_sys_in,
  input  wire logic rstn_in,
  interval_if.cnt   tmr
);
  logic [31:0]       pre;
  logic [TIME_W-1:0] cnt;

  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      pre         <= 32'h0;
      cnt         <= '0;
      tmr.expired <= 1'b1;
    end else if (tmr.load) begin
      pre         <= 32'h0;
      cnt         <= tmr.ticks;
      tmr.expired <= (tmr.ticks == '0);
    end else if (cnt != '0) begin
      if (pre == 32'(TICK_CYCLES - 1)) begin
        pre <= 32'h0;
        cnt <= cnt - 1'b1;
        if (cnt == TIME_W'(1)) begin
          tmr.expired <= 1'b1;
        end
      end else begin
        pre <= pre + 32'h1;
      end
    end
  end
endmodule // interval_timer

/* File: motor_stop_sequencer.sv */
/*
  Stop and DC brake sequencer of a motor drive, with register port.
  Assumes synchronous terminal inputs, output frequency as a fraction
  of maximum (1023 = max) and 12-bit analog inputs (full scale 10 V/20 mA).
*/
// The address map and the strobed register port were decided locally.
`timescale 1ns/1ps
module motor_stop_sequencer
  import motor_stop_pkg::*;
#(
  parameter int TICK_CYCLES = TICK_CYC
) (
  input  wire logic              clk_sys_in,
  input  wire logic              rstn_in,
  input  wire logic [ADDR_W-1:0] addr_in,
  input  wire logic [DATA_W-1:0] wdata_in,
  input  wire logic              wr_in,
  input  wire logic              rd_in,
  output logic      [DATA_W-1:0] rdata_out,
  input  wire logic              run_in,
  input  wire logic              jog_in,
  input  wire logic              mfi_in,
  input  wire logic [ANA_W-1:0]  analog2_in,
  input  wire logic [ANA_W-1:0]  analog3_in,
  input  wire logic [FREQ_W-1:0] out_freq_in,
  output logic                   drive_en_out,
  output logic                   dc_brake_out,
  output logic      [6:0]        brake_level_out,
  output logic                   ramp_down_out,
  output logic                   fast_stop_out,
  output logic                   run_locked_out
);
  interval_if tmr ();

  stop_method_t      method;
  stop_method_t      method_at_stop;
  logic              unit_sel;
  logic              flux_vec;
  logic [7:0]        mfi_sel;
  logic [7:0]        ana2_fn;
  logic [7:0]        ana3_fn;
  logic [6:0]        brk_pct;
  logic [6:0]        noload_pct;
  logic [15:0]       start_t;
  logic [15:0]       stop_t;
  logic [15:0]       min_off;
  logic [15:0]       decel_t;
  logic [15:0]       fast_t;
  logic [FREQ_W-1:0] freq_at_stop;
  state_t            state;
  state_t            next_state;
  logic              go;
  logic              fast_req;
  logic              dc_cmd;
  logic [6:0]        ana_pct;
  logic [6:0]        next_level;

  function automatic logic [15:0] clamp16(input logic [31:0] v, input logic [15:0] lim);
    return (v > {16'h0, lim}) ? lim : v[15:0];
  endfunction

  // Time unit select: 1 means 0.1 s steps, 0 means 0.01 s steps
  function automatic logic [TIME_W-1:0] to_ticks(input logic [15:0] raw, input logic unit);
    logic [TIME_W-1:0] t;
    t = TIME_W'(raw);
    return unit ? TIME_W'(t * UNIT_TENTH) : t;
  endfunction

  // Scale an interval by the output frequency fraction
  function automatic logic [TIME_W-1:0] fscale(input logic [TIME_W-1:0] t, input logic [FREQ_W-1:0] f);
    logic [TIME_W+FREQ_W-1:0] p;
    p = (TIME_W+FREQ_W)'(t) * (TIME_W+FREQ_W)'(f);
    return p[TIME_W+FREQ_W-1:FREQ_W];
  endfunction

  function automatic logic [6:0] ana_to_pct(input logic [ANA_W-1:0] a);
    logic [ANA_W+7:0] p;
    p = (ANA_W+8)'(a) * (ANA_W+8)'(ANA_SCALE);
    return p[ANA_W+6:ANA_W];
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Terminal decode

  always_comb begin
    go       = run_in || jog_in;
    fast_req = ((mfi_sel == MFI_FAST_NO) && mfi_in) || ((mfi_sel == MFI_FAST_NC) && !mfi_in);
    dc_cmd   = (mfi_sel == MFI_DC_BRK) && mfi_in;
    if (ana2_fn == ANA_FN_BRK) begin
      ana_pct = ana_to_pct(analog2_in);
    end else begin
      ana_pct = ana_to_pct(analog3_in);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register port

  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      method     <= STOP_RAMP;
      unit_sel   <= RST_UNIT;
      flux_vec   <= 1'b0;
      mfi_sel    <= 8'h00;
      ana2_fn    <= 8'h00;
      ana3_fn    <= 8'h00;
      brk_pct    <= RST_BRK_PCT;
      noload_pct <= RST_NOLOAD;
      start_t    <= RST_START_T;
      stop_t     <= RST_STOP_T;
      min_off    <= RST_MIN_OFF;
      decel_t    <= RST_RAMP_T;
      fast_t     <= RST_RAMP_T;
    end else if (wr_in) begin
      unique case (addr_in)
        OFS_CTRL: begin
          method   <= stop_method_t'(wdata_in[CTRL_METH_LSB +: 2]);
          unit_sel <= wdata_in[CTRL_UNIT_BIT];
          flux_vec <= wdata_in[CTRL_FLUX_BIT];
        end
        OFS_MFI:     mfi_sel <= wdata_in[7:0];
        OFS_ANA_FN: begin
          ana2_fn <= wdata_in[7:0];
          ana3_fn <= wdata_in[15:8];
        end
        OFS_BRK_PCT: begin
          if (state == ST_IDLE) begin
            brk_pct <= 7'(clamp16(wdata_in, 16'(PCT_MAX)));
          end
        end
        OFS_NOLOAD:  noload_pct <= 7'(clamp16(wdata_in, 16'(PCT_MAX)));
        OFS_START_T: start_t <= clamp16(wdata_in, BRK_T_MAX);
        OFS_STOP_T:  stop_t  <= clamp16(wdata_in, BRK_T_MAX);
        OFS_MIN_OFF: min_off <= wdata_in[15:0];
        OFS_DECEL_T: decel_t <= clamp16(wdata_in, RAMP_T_MAX);
        OFS_FAST_T:  fast_t  <= clamp16(wdata_in, RAMP_T_MAX);
        default: ;
      endcase
    end
  end

  // Read data stand for exactly the cycle after the strobe
  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      rdata_out <= '0;
    end else if (!rd_in) begin
      rdata_out <= '0;
    end else begin
      unique case (addr_in)
        OFS_CTRL:    rdata_out <= 32'({flux_vec, unit_sel, method});
        OFS_MFI:     rdata_out <= 32'(mfi_sel);
        OFS_ANA_FN:  rdata_out <= 32'({ana3_fn, ana2_fn});
        OFS_BRK_PCT: rdata_out <= 32'(brk_pct);
        OFS_NOLOAD:  rdata_out <= 32'(noload_pct);
        OFS_START_T: rdata_out <= 32'(start_t);
        OFS_STOP_T:  rdata_out <= 32'(stop_t);
        OFS_MIN_OFF: rdata_out <= 32'(min_off);
        OFS_DECEL_T: rdata_out <= 32'(decel_t);
        OFS_FAST_T:  rdata_out <= 32'(fast_t);
        OFS_STATUS:  rdata_out <= 32'({freq_at_stop, 4'h0, method_at_stop, 4'h0, state});
        default:     rdata_out <= '0;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer

  always_comb begin
    next_state = state;
    tmr.load   = 1'b0;
    tmr.ticks  = '0;
    unique case (state)
      ST_IDLE, ST_EXT_BRK: begin
        // Fast-stop input still asserted keeps the drive from starting
        if (go && !fast_req) begin
          if (start_t != 16'h0) begin
            next_state = ST_START_BRK;
            tmr.load   = 1'b1;
            tmr.ticks  = TIME_W'(start_t);
          end else begin
            next_state = ST_RUN;
          end
        end else if (dc_cmd) begin
          next_state = ST_EXT_BRK;
        end else begin
          next_state = ST_IDLE;
        end
      end
      ST_START_BRK, ST_RUN, ST_RAMP: begin
        if (fast_req) begin
          next_state = ST_FAST;
          tmr.load   = 1'b1;
          tmr.ticks  = to_ticks(fast_t, unit_sel);
        end else if (state == ST_START_BRK) begin
          if (!go) begin
            next_state = ST_IDLE;
          end else if (tmr.expired) begin
            next_state = ST_RUN;
          end
        end else if (state == ST_RAMP) begin
          if (go) begin
            next_state = ST_RUN;
          end else if (tmr.expired) begin
            next_state = ST_IDLE;
          end
        end else if (!go) begin
          tmr.load = 1'b1;
          unique case (method)
            STOP_RAMP: begin
              next_state = ST_RAMP;
              tmr.ticks  = fscale(to_ticks(decel_t, unit_sel), out_freq_in);
            end
            STOP_COAST, STOP_DCB: begin
              next_state = ST_OFF_WAIT;
              tmr.ticks  = TIME_W'(min_off);
            end
            STOP_TIMED: begin
              next_state = ST_COAST_LCK;
              tmr.ticks  = fscale(to_ticks(decel_t, unit_sel), out_freq_in);
            end
          endcase
        end
      end
      ST_OFF_WAIT: begin
        // Run is not looked at until the interval is over
        if (tmr.expired) begin
          if (method_at_stop == STOP_DCB && stop_t != 16'h0) begin
            next_state = ST_STOP_BRK;
            tmr.load   = 1'b1;
            // Floor keeps a brake at low stop frequency from vanishing
            tmr.ticks  = fscale(TIME_W'(stop_t), (freq_at_stop < FREQ_FLOOR) ? FREQ_FLOOR : freq_at_stop);
          end else begin
            next_state = ST_IDLE;
          end
        end
      end
      ST_STOP_BRK, ST_COAST_LCK: begin
        if (tmr.expired) begin
          next_state = ST_IDLE;
        end
      end
      ST_FAST: begin
        if (tmr.expired) begin
          next_state = ST_FAST_HOLD;
        end
      end
      ST_FAST_HOLD: begin
        if (!go && !fast_req) begin
          next_state = ST_IDLE;
        end
      end
      default: next_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      state <= ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      freq_at_stop   <= '0;
      method_at_stop <= STOP_RAMP;
    end else if (state == ST_RUN && next_state != ST_RUN) begin
      freq_at_stop   <= out_freq_in;
      method_at_stop <= method;
    end
  end

  interval_timer #(
    .TICK_CYCLES (TICK_CYCLES)
  ) u_timer (
    .clk_sys_in (clk_sys_in),
    .rstn_in    (rstn_in),
    .tmr        (tmr.cnt)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Outputs, registered from the next state

  always_comb begin
    if (next_state == ST_START_BRK && flux_vec) begin
      next_level = noload_pct;
    end else if (ana2_fn == ANA_FN_BRK || ana3_fn == ANA_FN_BRK) begin
      next_level = ana_pct;
    end else begin
      next_level = brk_pct;
    end
  end

  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      drive_en_out    <= 1'b0;
      dc_brake_out    <= 1'b0;
      brake_level_out <= 7'h00;
      ramp_down_out   <= 1'b0;
      fast_stop_out   <= 1'b0;
      run_locked_out  <= 1'b0;
    end else begin
      drive_en_out    <= next_state inside {ST_RUN, ST_RAMP, ST_FAST};
      dc_brake_out    <= next_state inside {ST_START_BRK, ST_STOP_BRK, ST_EXT_BRK};
      brake_level_out <= next_level;
      ramp_down_out   <= next_state == ST_RAMP;
      fast_stop_out   <= next_state inside {ST_FAST, ST_FAST_HOLD};
      run_locked_out  <= next_state inside {ST_OFF_WAIT, ST_STOP_BRK, ST_COAST_LCK, ST_FAST_HOLD};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!rstn_in);

  coast_cut_a: assert property (
    state == ST_RUN && !go && !fast_req && method == STOP_COAST |=> !drive_en_out && run_locked_out)
    else $error("coast stop left drive on");
  coast_lock_a: assert property (
    state == ST_OFF_WAIT && !tmr.expired |=> state == ST_OFF_WAIT && !drive_en_out)
    else $error("run accepted during output-off interval");
  dcb_after_wait_a: assert property (
    state == ST_OFF_WAIT && tmr.expired && method_at_stop == STOP_DCB && stop_t != 16'h0
    |=> dc_brake_out && state == ST_STOP_BRK)
    else $error("stop brake not applied after wait");
  dcb_length_a: assert property (
    state == ST_STOP_BRK && !tmr.expired |=> state == ST_STOP_BRK && dc_brake_out)
    else $error("stop brake ended before its interval");
  dcb_skip_a: assert property (
    state == ST_OFF_WAIT && tmr.expired && stop_t == 16'h0 |=> state == ST_IDLE && !dc_brake_out)
    else $error("zero stop brake time still braked");
  timed_coast_a: assert property (
    state == ST_RUN && !go && !fast_req && method == STOP_TIMED
    |=> !drive_en_out ##0 (state == ST_COAST_LCK || state == ST_IDLE))
    else $error("timed coast did not cut output");
  start_skip_a: assert property (
    state == ST_IDLE && go && !fast_req && start_t == 16'h0 |=> state == ST_RUN && drive_en_out && !dc_brake_out)
    else $error("start brake with zero time");
  pct_frozen_a: assert property (
    state != ST_IDLE && wr_in && addr_in == OFS_BRK_PCT |=> $stable(brk_pct))
    else $error("brake current changed while running");
  flux_level_a: assert property (
    next_state == ST_START_BRK && flux_vec |=> brake_level_out == $past(noload_pct))
    else $error("start brake not at no-load current");
  ext_brake_a: assert property (
    state == ST_IDLE && dc_cmd && !go |=> dc_brake_out ##1 (dc_brake_out || !dc_cmd))
    else $error("brake command not honoured");
  ext_resume_a: assert property (
    state == ST_EXT_BRK && go && !fast_req |=> state inside {ST_RUN, ST_START_BRK})
    else $error("run did not end commanded braking");
  fast_entry_a: assert property (
    state == ST_RUN && fast_req |=> fast_stop_out && state == ST_FAST)
    else $error("fast stop not taken");
  fast_hold_a: assert property (
    state == ST_FAST_HOLD && (go || fast_req) |=> state == ST_FAST_HOLD && !drive_en_out)
    else $error("restart allowed after fast stop");

  coast_seen_c: cover property (state == ST_OFF_WAIT ##1 state == ST_IDLE);
  stop_brk_c:   cover property (state == ST_STOP_BRK ##1 state == ST_IDLE);
  fast_seen_c:  cover property (state == ST_FAST_HOLD ##1 state == ST_IDLE);
  ext_brk_c:    cover property (state == ST_EXT_BRK ##1 state == ST_RUN);
endmodule // motor_stop_sequencer

/* File: terminal_model.sv */
/*
  Model of the control terminals and power stage facing the sequencer.
  Assumes requests from the bench change just after a rising edge.
*/
`timescale 1ns/1ps
module terminal_model (
  input  wire logic       clk_sys_in,
  input  wire logic       run_req_in,
  input  wire logic       jog_req_in,
  input  wire logic       fast_req_in,
  input  wire logic       brk_req_in,
  input  wire logic       nc_mode_in,
  input  wire logic [9:0] freq_req_in,
  output logic            run_out,
  output logic            jog_out,
  output logic            mfi_out,
  output logic      [9:0] freq_out
);
  // Contacts settle one edge after the operator acts
  always_ff @(posedge clk_sys_in) begin
    run_out  <= run_req_in;
    jog_out  <= jog_req_in;
    mfi_out  <= brk_req_in | (nc_mode_in ? ~fast_req_in : fast_req_in);
    freq_out <= freq_req_in;
  end
endmodule  // terminal_model

/* File: motor_stop_sequencer_test.sv */
/*
  Self-checking bench of the stop sequencer, random values from an LFSR.
  Assumes a 4-cycle tick so every interval stays short.
*/
`timescale 1ns/1ps
module motor_stop_sequencer_test;
  import motor_stop_pkg::*;
  localparam int TCK = 4;
  logic clk_sys_in = 0, rstn_in = 0, wr_in = 0, rd_in = 0;
  logic [7:0] addr_in = 8'h00;
  logic [31:0] wdata_in = 32'h0, rdata_out, d;
  logic run_req = 0, jog_req = 0, fast_req = 0, brk_req = 0, nc_mode = 0;
  logic run_in, jog_in, mfi_in, drive_en_out, dc_brake_out, ramp_down_out, fast_stop_out, run_locked_out;
  logic [9:0] freq_req = 10'h3ff, out_freq_in;
  logic [11:0] ana2 = 12'h000, ana3 = 12'h000, a;
  logic [6:0] brake_level_out;
  logic [15:0] seed = 16'hf70c;
  int err_total = 0, total_checks = 0, cyc = 0, n, x, f, st;
  logic [31:0] rv_a [10] = '{32'h00, 32'h0c, 32'h10, 32'h14, 32'h18, 32'h1c, 32'h20, 32'h24, 32'h28, 32'h40};
  logic [31:0] rv_e [10] = '{32'h4, 32'h32, 32'h1e, 32'h0, 32'h32, 32'h32, 32'h64, 32'h64, 32'h0, 32'h0};

  always #25 clk_sys_in = ~clk_sys_in;
  terminal_model i_term (.clk_sys_in(clk_sys_in), .run_req_in(run_req), .jog_req_in(jog_req),
    .fast_req_in(fast_req), .brk_req_in(brk_req), .nc_mode_in(nc_mode), .freq_req_in(freq_req),
    .run_out(run_in), .jog_out(jog_in), .mfi_out(mfi_in), .freq_out(out_freq_in));
  motor_stop_sequencer #(.TICK_CYCLES(TCK)) i_dut (.clk_sys_in(clk_sys_in), .rstn_in(rstn_in),
    .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
    .run_in(run_in), .jog_in(jog_in), .mfi_in(mfi_in), .analog2_in(ana2), .analog3_in(ana3),
    .out_freq_in(out_freq_in), .drive_en_out(drive_en_out), .dc_brake_out(dc_brake_out),
    .brake_level_out(brake_level_out), .ramp_down_out(ramp_down_out),
    .fast_stop_out(fast_stop_out), .run_locked_out(run_locked_out));

  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  function automatic logic outb(input int k);
    case (k)
      0: return drive_en_out;
      1: return dc_brake_out;
      2: return ramp_down_out;
      3: return fast_stop_out;
      default: return run_locked_out;
    endcase
  endfunction
  // Counted length versus ticks, allowing the prescaler phase
  function automatic logic inr(input int c, input int e);
    return c >= TCK * e - 1 && c <= TCK * e + 3;
  endfunction
  function automatic int brk_ticks(input int t, input int fr);
    return t * (fr < 102 ? 102 : fr) / 1024;
  endfunction
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("[FAIL] %0t ns: got %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] ad, input logic [31:0] dt);
    @(posedge clk_sys_in);
    wr_in <= 1'b1;
    addr_in <= ad;
    wdata_in <= dt;
    @(posedge clk_sys_in);
    wr_in <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] ad, output logic [31:0] dt);
    @(posedge clk_sys_in);
    rd_in <= 1'b1;
    addr_in <= ad;
    @(posedge clk_sys_in);
    rd_in <= 1'b0;
    #1 dt = rdata_out;
  endtask
  // Bounded wait for an output level; count of cycles spent
  task automatic wt(input int k, input logic v, output int c);
    c = 0;
    while (outb(k) !== v && c < 600) begin
      @(posedge clk_sys_in);
      #1 c++;
    end
  endtask
  task automatic span(input int k, output int c);
    wt(k, 1'b1, x);
    c = 0;
    while (outb(k) === 1'b1 && c < 5000) begin
      @(posedge clk_sys_in);
      #1 c++;
    end
  endtask
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // Ceiling well above the longest expected run
  always @(posedge clk_sys_in) begin
    cyc++;
    if (cyc == 40000) begin
      err_total++;
      wrap_up();
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (20) @(posedge clk_sys_in);
    rstn_in <= 1'b1;
    for (int i = 0; i < 10; i++) begin
      rd(rv_a[i][7:0], d);
      chk(d, rv_e[i]);
    end
    wr(8'h0c, 32'hc8);
    rd(8'h0c, d);
    chk(d, 32'h64);
    $display("test reset_values done");
    wr(8'h1c, 32'h2);
    wr(8'h14, 32'h2);
    for (int i = 0; i < 2; i++) begin
      wr(8'h00, {28'h0, i[0], 3'b101});
      run_req <= 1'b1;
      wt(1, 1'b1, x);
      chk({25'h0, brake_level_out}, i ? 32'h1e : 32'h64);
      span(1, n);
      chk(inr(n, 2), 1'b1);
      wt(0, 1'b1, x);
      chk(drive_en_out, 1'b1);
      wr(8'h0c, 32'h14);
      rd(8'h0c, d);
      chk(d, 32'h64);
      run_req <= 1'b0;
      wt(0, 1'b0, n);
      chk(n <= 3 && run_locked_out === 1'b1, 1'b1);
      run_req <= 1'b1;
      span(4, n);
      chk(inr(n, 2), 1'b1);
      run_req <= 1'b0;
      repeat (14) @(posedge clk_sys_in);
    end
    $display("test coast_start_brake done");
    wr(8'h00, 32'h6);
    wr(8'h14, 32'h0);
    for (int i = 0; i < 3; i++) begin
      st = (i == 0) ? 0 : (i == 1) ? 20 : 20 + int'(seed[5:0]);
      f = (i == 1) ? 1023 : int'(seed[9:0]);
      freq_req <= f[9:0];
      wr(8'h18, st);
      run_req <= 1'b1;
      wt(0, 1'b1, x);
      run_req <= 1'b0;
      wt(0, 1'b0, x);
      wt(1, 1'b1, n);
      if (st == 0) chk(dc_brake_out, 1'b0);
      else begin
        chk(inr(n, 2), 1'b1);
        span(1, n);
        chk(inr(n, brk_ticks(st, f)), 1'b1);
      end
      wt(4, 1'b0, x);
      rd(8'h28, d);
      chk({d[23:14], d[9:8], d[3:0]}, {f[9:0], 2'h2, 4'h0});
      seed = lfsr(seed);
    end
    $display("test dc_stop done");
    wr(8'h00, 32'h7);
    wr(8'h20, 32'h2);
    for (int i = 0; i < 2; i++) begin
      f = int'(seed[9:0]) | 64;
      freq_req <= f[9:0];
      run_req <= 1'b1;
      wt(0, 1'b1, x);
      run_req <= 1'b0;
      span(4, n);
      chk(inr(n, 20 * f / 1024), 1'b1);
      seed = lfsr(seed);
    end
    $display("test timed_coast done");
    freq_req <= 10'h3ff;
    wr(8'h00, 32'h4);
    run_req <= 1'b1;
    wt(0, 1'b1, x);
    run_req <= 1'b0;
    wt(2, 1'b1, n);
    chk(n <= 3 && drive_en_out === 1'b1, 1'b1);
    wt(2, 1'b0, x);
    $display("test ramp done");
    wr(8'h04, 32'h3c);
    for (int i = 0; i < 2; i++) begin
      a = i ? seed[11:0] : 12'hfff;
      // Second pass takes the brake current from channel three
      wr(8'h08, i ? 32'h600 : 32'h6);
      ana2 <= i ? ~a : a;
      ana3 <= i ? a : ~a;
      brk_req <= 1'b1;
      wt(1, 1'b1, x);
      chk({25'h0, brake_level_out}, (32'(a) * 101) >> 12);
      jog_req <= 1'b1;
      wt(1, 1'b0, x);
      wt(0, 1'b1, x);
      chk(drive_en_out, 1'b1);
      jog_req <= 1'b0;
      brk_req <= 1'b0;
      wt(2, 1'b1, x);
      wt(2, 1'b0, x);
      seed = lfsr(seed);
    end
    $display("test dc_command done");
    for (int i = 0; i < 2; i++) begin
      wr(8'h04, i ? 32'h11 : 32'h0f);
      nc_mode <= i[0];
      wr(8'h00, i ? 32'h1 : 32'h5);
      wr(8'h24, 32'h3);
      run_req <= 1'b1;
      wt(0, 1'b1, x);
      fast_req <= 1'b1;
      wt(3, 1'b1, x);
      wt(4, 1'b1, n);
      chk(inr(n, i ? 3 : 30), 1'b1);
      fast_req <= 1'b0;
      repeat (8) @(posedge clk_sys_in);
      #1 chk(run_locked_out, 1'b1);
      run_req <= 1'b0;
      wt(4, 1'b0, x);
      chk(fast_stop_out, 1'b0);
    end
    $display("test fast_stop done");
    wrap_up();
  end
endmodule  // motor_stop_sequencer_test
